// [logic/virtual_memory_unit.sv]
// Address translation and checking between requesters and memory control
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "vmu_params.svh"
module virtual_memory_unit
  import vmu_pkg::*;
#(
  parameter int AW          = 32,
  parameter int INIT_CYCLES = `VMU_INIT_CYCLES
) (
  input  wire logic          clk_sys_i,
  input  wire logic          reset_i,
  // Avalon-MM register slave
  input  wire logic [6:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  input  wire logic [3:0]    avs_byteenable_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  // Control memory bus requester
  input  wire logic          cm_req_i,
  input  wire logic [AW-1:0] cm_addr_i,
  // Processor requester
  input  wire logic          cpu_req_i,
  input  wire logic [AW-1:0] cpu_addr_i,
  output logic               cpu_ready_o,
  // Packet memory bus requester
  input  wire logic          pm_req_i,
  input  wire logic [AW-1:0] pm_addr_i,
  output logic               pm_ready_o,
  // Control memory controller
  output logic               cmc_req_o,
  output logic      [AW-1:0] cmc_addr_o,
  // Packet memory controller
  output logic               pmc_req_o,
  output logic      [AW-1:0] pmc_addr_o,
  output logic               pmc_map_o,
  input  wire logic          map_valid_i,
  input  wire logic [31:0]   map_rdata_i,
  // Events
  output logic               irq_o,
  output logic               mem_lock_o
);

  // ****************************************************
  // Registers
  // ****************************************************
  logic [AW-1:0] vbase_ff, ocm_base_ff, cm_base_ff, pm_base_ff, total_ff;
  logic [AW-1:0] pm_ofs_ff, max_buf_ff, last_real_ff, map_base_ff;
  logic [AW-1:0] real_base_ff;
  logic [31:0]   seg_size_ff;
  logic [4:0]    buf_sh_ff;
  logic [`VMU_ST_W-1:0] ctrl_ff, status_ff, int_en_ff, lock_en_ff;
  logic          ack_ff;
  logic [31:0]   rdata_ff;
  logic          wr_fire;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Answer one cycle after the request is seen; data stands at that edge
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
  assign wr_fire           = avs_write_i & ack_ff;
  assign avs_readdata_o    = rdata_ff;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
    end
  end

  // ****************************************************
  // Init state machine and virtual path state
  // ****************************************************
  init_state_t init_st_ff;
  virt_state_t virt_st_ff;
  logic [15:0] init_cnt_ff;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_ff <= 32'h0;
    end else if (avs_read_i && !ack_ff) begin
      if (avs_address_i == `VMU_OFS_VBASE) begin
        rdata_ff <= vbase_ff;
      end else if (avs_address_i == `VMU_OFS_OCM_BASE) begin
        rdata_ff <= ocm_base_ff;
      end else if (avs_address_i == `VMU_OFS_CM_BASE) begin
        rdata_ff <= cm_base_ff;
      end else if (avs_address_i == `VMU_OFS_PM_BASE) begin
        rdata_ff <= pm_base_ff;
      end else if (avs_address_i == `VMU_OFS_TOTAL) begin
        rdata_ff <= total_ff;
      end else if (avs_address_i == `VMU_OFS_BUF_SIZE) begin
        rdata_ff <= {27'h0, buf_sh_ff};
      end else if (avs_address_i == `VMU_OFS_PM_OFS) begin
        rdata_ff <= pm_ofs_ff;
      end else if (avs_address_i == `VMU_OFS_MAX_BUF) begin
        rdata_ff <= max_buf_ff;
      end else if (avs_address_i == `VMU_OFS_CTRL) begin
        rdata_ff <= {30'h0, ctrl_ff};
      end else if (avs_address_i == `VMU_OFS_STATUS) begin
        rdata_ff <= {30'h0, status_ff};
      end else if (avs_address_i == `VMU_OFS_INT_EN) begin
        rdata_ff <= {30'h0, int_en_ff};
      end else if (avs_address_i == `VMU_OFS_LOCK_EN) begin
        rdata_ff <= {30'h0, lock_en_ff};
      end else if (avs_address_i == `VMU_OFS_STATE) begin
        rdata_ff <= {27'h0, virt_st_ff, init_st_ff};
      end else if (avs_address_i == `VMU_OFS_LAST_REAL) begin
        rdata_ff <= last_real_ff;
      end else if (avs_address_i == `VMU_OFS_SEG_SIZE) begin
        rdata_ff <= seg_size_ff;
      end else if (avs_address_i == `VMU_OFS_MAP_BASE) begin
        rdata_ff <= map_base_ff;
      end else if (avs_address_i == `VMU_OFS_REAL_BASE) begin
        rdata_ff <= real_base_ff;
      end else begin
        rdata_ff <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      vbase_ff     <= '0;
      ocm_base_ff  <= '0;
      cm_base_ff   <= '0;
      pm_base_ff   <= '0;
      total_ff     <= '0;
      buf_sh_ff    <= `VMU_BUF_SIZE_RST;
      pm_ofs_ff    <= '0;
      max_buf_ff   <= `VMU_MAX_BUF_RST;
      ctrl_ff      <= '0;
      int_en_ff    <= '0;
      lock_en_ff   <= '0;
      seg_size_ff  <= 32'h0;
      map_base_ff  <= '0;
      real_base_ff <= '0;
    end else if (wr_fire) begin
      if (avs_address_i == `VMU_OFS_VBASE) begin
        vbase_ff <= merge(vbase_ff, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_OCM_BASE) begin
        ocm_base_ff <= merge(ocm_base_ff, avs_writedata_i,
                             avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_CM_BASE) begin
        cm_base_ff <= merge(cm_base_ff, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_PM_BASE) begin
        pm_base_ff <= merge(pm_base_ff, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_TOTAL) begin
        total_ff <= merge(total_ff, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_BUF_SIZE) begin
        if (avs_byteenable_i[0]) begin
          buf_sh_ff <= avs_writedata_i[4:0];
        end
      end else if (avs_address_i == `VMU_OFS_PM_OFS) begin
        pm_ofs_ff <= merge(pm_ofs_ff, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_MAX_BUF) begin
        max_buf_ff <= merge(max_buf_ff, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_CTRL) begin
        if (avs_byteenable_i[0]) begin
          ctrl_ff <= avs_writedata_i[`VMU_ST_W-1:0];
        end
      end else if (avs_address_i == `VMU_OFS_INT_EN) begin
        if (avs_byteenable_i[0]) begin
          int_en_ff <= avs_writedata_i[`VMU_ST_W-1:0];
        end
      end else if (avs_address_i == `VMU_OFS_LOCK_EN) begin
        if (avs_byteenable_i[0]) begin
          lock_en_ff <= avs_writedata_i[`VMU_ST_W-1:0];
        end
      end else if (avs_address_i == `VMU_OFS_SEG_SIZE) begin
        seg_size_ff <= merge(seg_size_ff, avs_writedata_i,
                             avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_MAP_BASE) begin
        map_base_ff <= merge(map_base_ff, avs_writedata_i,
                             avs_byteenable_i);
      end else if (avs_address_i == `VMU_OFS_REAL_BASE) begin
        real_base_ff <= merge(real_base_ff, avs_writedata_i,
                              avs_byteenable_i);
      end
    end
  end

  // ****************************************************
  // Segment-size initialization
  // ****************************************************
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      init_st_ff  <= INIT_IDLE;
      init_cnt_ff <= 16'h0;
    end else begin
      case (init_st_ff)
        INIT_IDLE: begin
          if (wr_fire && avs_address_i == `VMU_OFS_SEG_SIZE) begin
            init_st_ff  <= INIT_RUN;
            init_cnt_ff <= 16'(INIT_CYCLES - 1);
          end
        end
        INIT_RUN: begin
          if (init_cnt_ff == 16'h0) begin
            init_st_ff <= INIT_IDLE;
          end else begin
            init_cnt_ff <= init_cnt_ff - 16'h1;
          end
        end
        default: init_st_ff <= INIT_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Routing and translation
  // ****************************************************
  logic          cpu_to_cm;
  logic          pkt_req;
  logic [AW-1:0] pkt_addr;
  logic [AW-1:0] v_index, v_inbuf;
  logic          v_idx_err, v_off_err;
  logic          is_virt;
  logic          halt_idx, halt_off;
  logic [AW-1:0] inbuf_ff;
  logic [15:0]   real_idx_ff;
  logic          virt_accept;
  logic          cm_go;
  logic [AW-1:0] cm_src;

  assign cpu_to_cm = cpu_addr_i < pm_base_ff;
  // Dedicated buses win; processor waits when its target bus is in use
  assign cm_go     = cm_req_i | (cpu_req_i & cpu_to_cm);
  assign cm_src    = cm_req_i ? cm_addr_i : cpu_addr_i;
  assign pm_ready_o  = virt_st_ff == VS_IDLE && init_st_ff == INIT_IDLE;
  assign cpu_ready_o = cpu_to_cm ? ~cm_req_i : (pm_ready_o & ~pm_req_i);
  assign pkt_req   = pm_ready_o & (pm_req_i | (cpu_req_i & ~cpu_to_cm));
  assign pkt_addr  = pm_req_i ? pm_addr_i : cpu_addr_i;
  assign is_virt   = pkt_addr >= vbase_ff;
  // A halted access is dropped; only the status flag records it
  assign halt_idx  = v_idx_err & ctrl_ff[`VMU_ST_INDEX_ERR];
  assign halt_off  = v_off_err & ctrl_ff[`VMU_ST_OFFSET_ERR];
  assign virt_accept = pkt_req & is_virt;

  vmu_addr_calc #(
    .AW (AW)
  ) u_calc (
    .addr_i       (pkt_addr),
    .vbase_i      (vbase_ff),
    .total_i      (total_ff),
    .size_sh_i    (buf_sh_ff),
    .max_buf_i    (max_buf_ff),
    .index_o      (v_index),
    .inbuf_o      (v_inbuf),
    .index_err_o  (v_idx_err),
    .offset_err_o (v_off_err)
  );

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmc_req_o  <= 1'b0;
      cmc_addr_o <= '0;
    end else begin
      cmc_req_o  <= cm_go;
      cmc_addr_o <= cm_src - cm_base_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      virt_st_ff   <= VS_IDLE;
      pmc_req_o    <= 1'b0;
      pmc_addr_o   <= '0;
      pmc_map_o    <= 1'b0;
      inbuf_ff     <= '0;
      real_idx_ff  <= 16'h0;
      last_real_ff <= '0;
    end else begin
      pmc_req_o <= 1'b0;
      pmc_map_o <= 1'b0;
      case (virt_st_ff)
        VS_IDLE: begin
          if (pkt_req && !is_virt) begin
            pmc_req_o  <= 1'b1;
            pmc_addr_o <= pkt_addr - pm_base_ff + pm_ofs_ff;
          end else if (virt_accept && !halt_idx && !halt_off) begin
            pmc_req_o  <= 1'b1;
            pmc_map_o  <= 1'b1;
            pmc_addr_o <= map_base_ff + pm_ofs_ff +
                          (v_index << `VMU_MAP_ENTRY_SH);
            inbuf_ff   <= v_inbuf;
            virt_st_ff <= VS_MAP;
          end
        end
        VS_MAP: begin
          if (map_valid_i) begin
            real_idx_ff <= map_rdata_i[15:0];
            virt_st_ff  <= VS_FWD;
          end
        end
        VS_FWD: begin
          pmc_req_o    <= 1'b1;
          pmc_addr_o   <= real_base_ff + pm_ofs_ff + inbuf_ff +
                          ({{(AW-16){1'b0}}, real_idx_ff} << buf_sh_ff);
          last_real_ff <= real_base_ff + inbuf_ff +
                          ({{(AW-16){1'b0}}, real_idx_ff} << buf_sh_ff);
          virt_st_ff   <= VS_IDLE;
        end
        default: virt_st_ff <= VS_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Status, interrupt and lock
  // ****************************************************
  logic [`VMU_ST_W-1:0] ev;
  logic [`VMU_ST_W-1:0] w1c;

  assign ev[`VMU_ST_INDEX_ERR]  = virt_accept & v_idx_err;
  assign ev[`VMU_ST_OFFSET_ERR] = virt_accept & v_off_err;
  assign w1c = (wr_fire && avs_address_i == `VMU_OFS_STATUS &&
                avs_byteenable_i[0]) ? avs_writedata_i[`VMU_ST_W-1:0]
                                     : '0;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~w1c) | ev;   // Set wins over clear
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_o      <= 1'b0;
      mem_lock_o <= 1'b0;
    end else begin
      irq_o      <= |(status_ff & int_en_ff);
      mem_lock_o <= |(status_ff & lock_en_ff);
    end
  end

endmodule : virtual_memory_unit
`default_nettype wire

// [logic/vmu_params.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef VMU_PARAMS_SVH
`define VMU_PARAMS_SVH

`define VMU_OFS_VBASE     7'h00
`define VMU_OFS_OCM_BASE  7'h04
`define VMU_OFS_CM_BASE   7'h08
`define VMU_OFS_PM_BASE   7'h0c
`define VMU_OFS_TOTAL     7'h10
`define VMU_OFS_BUF_SIZE  7'h14
`define VMU_OFS_PM_OFS    7'h18
`define VMU_OFS_MAX_BUF   7'h1c
`define VMU_OFS_CTRL      7'h20
`define VMU_OFS_STATUS    7'h24
`define VMU_OFS_INT_EN    7'h28
`define VMU_OFS_LOCK_EN   7'h2c
`define VMU_OFS_STATE     7'h30
`define VMU_OFS_LAST_REAL 7'h34
`define VMU_OFS_SEG_SIZE  7'h38
`define VMU_OFS_MAP_BASE  7'h3c
`define VMU_OFS_REAL_BASE 7'h40

`define VMU_ST_INDEX_ERR  0
`define VMU_ST_OFFSET_ERR 1
`define VMU_ST_W          2

`define VMU_MAX_BUF_RST   32'hffffffff
`define VMU_BUF_SIZE_RST  5'h0c
`define VMU_MAP_ENTRY_SH  3
`define VMU_GRAN_SH       3
`define VMU_INIT_CYCLES   16

`endif

// [logic/vmu_pkg.sv]
// Types shared by the virtual memory unit files
`default_nettype none
package vmu_pkg;
  typedef enum logic [1:0] {
    INIT_IDLE = 2'b01,
    INIT_RUN  = 2'b10
  } init_state_t;

  typedef enum logic [2:0] {
    VS_IDLE = 3'b001,
    VS_MAP  = 3'b010,
    VS_FWD  = 3'b100
  } virt_state_t;
endpackage : vmu_pkg
`default_nettype wire

// [logic/vmu_addr_calc.sv]
// Virtual address split and limit checks
`timescale 1ns/1ps
`default_nettype none
`include "vmu_params.svh"
module vmu_addr_calc
  import vmu_pkg::*;
#(
  parameter int AW = 32
) (
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [AW-1:0] vbase_i,
  input  wire logic [AW-1:0] total_i,
  input  wire logic [4:0]    size_sh_i,
  input  wire logic [AW-1:0] max_buf_i,
  output logic      [AW-1:0] index_o,
  output logic      [AW-1:0] inbuf_o,
  output logic               index_err_o,
  output logic               offset_err_o
);
  logic [AW-1:0] offset;
  logic [AW-1:0] size_mask;

  always_comb begin
    offset       = addr_i - vbase_i;
    size_mask    = ~({AW{1'b1}} << size_sh_i);
    index_o      = offset >> size_sh_i;
    inbuf_o      = offset & size_mask;
    // Whole buffers only: an index past the last full buffer is an error
    index_err_o  = index_o >= (total_i >> size_sh_i);
    // Eight-byte granules, so a limit of ff8 still admits fff
    offset_err_o = (inbuf_o >> `VMU_GRAN_SH) >
                   (max_buf_i >> `VMU_GRAN_SH);
  end
endmodule : vmu_addr_calc
`default_nettype wire

// [tb/vmu_chk.sv]
// Port assertions for the virtual memory unit
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module vmu_chk (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic cm_req_i,
  input wire logic cpu_req_i,
  input wire logic cpu_ready_o,
  input wire logic pm_ready_o,
  input wire logic cmc_req_o,
  input wire logic pmc_req_o,
  input wire logic pmc_map_o,
  input wire logic map_valid_i,
  input wire logic irq_o,
  input wire logic mem_lock_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  a_wait_once: assert property (
    ($rose(avs_read_i) || $rose(avs_write_i))
    |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("register bus wait is not one cycle");
  a_cm_forward: assert property (cm_req_i |=> cmc_req_o)
    else $error("control request not forwarded");
  a_ctl_cause: assert property (
    cmc_req_o |-> $past(cm_req_i || (cpu_req_i && cpu_ready_o)))
    else $error("control forward without a request");
  a_map_fetch: assert property (
    pmc_map_o |-> pmc_req_o && !pm_ready_o && $past(pm_ready_o))
    else $error("map fetch out of turn");
  a_fwd_after: assert property (
    map_valid_i |=> !pm_ready_o ##1 (pm_ready_o && pmc_req_o && !pmc_map_o))
    else $error("real forward not two cycles after map entry");
  a_real_cause: assert property (
    pmc_req_o && !pmc_map_o |-> $past(pm_ready_o) || $past(map_valid_i, 2))
    else $error("packet forward without a request");
  a_irq_sticky: assert property (
    irq_o && !avs_write_i && !$past(avs_write_i) |=> irq_o)
    else $error("interrupt dropped without a write");
  a_lock_sticky: assert property (
    mem_lock_o && !avs_write_i && !$past(avs_write_i) |=> mem_lock_o)
    else $error("lock dropped without a write");
  a_reset_quiet: assert property (@(posedge clk_sys_i) disable iff (1'b0)
    reset_i |=> !(irq_o || mem_lock_o || cmc_req_o || pmc_req_o))
    else $error("output active after reset");
  cover property (pmc_map_o);
  cover property ($rose(irq_o));
  cover property ($rose(mem_lock_o));
  cover property (cmc_req_o);
endmodule : vmu_chk
bind virtual_memory_unit vmu_chk vmu_chk_inst (
  .clk_sys_i, .reset_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .cm_req_i, .cpu_req_i, .cpu_ready_o, .pm_ready_o, .cmc_req_o,
  .pmc_req_o, .pmc_map_o, .map_valid_i, .irq_o, .mem_lock_o);
`default_nettype wire

// [tb/vmu_map_mem.sv]
// Packet memory model answering buffer map fetches
`timescale 1ns/1ps
`default_nettype none
// ********
// Map memory
// ********
module vmu_map_mem (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        fetch_i,
  input  wire logic [31:0] entry_i,
  input  wire logic [3:0]  lag_i,
  output logic             valid_o,
  output logic      [31:0] rdata_o
);
  logic [4:0] cnt_ff;
  // Data toggles outside the answer so a stale word is never mistaken
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_ff  <= 5'h00;
      valid_o <= 1'b0;
      rdata_o <= 32'h0;
    end else begin
      valid_o <= (cnt_ff == 5'h01);
      rdata_o <= (cnt_ff == 5'h01) ? entry_i : ~rdata_o;
      if (fetch_i) begin
        cnt_ff <= {1'b0, lag_i} + 5'h01;
      end else if (cnt_ff != 5'h00) begin
        cnt_ff <= cnt_ff - 5'h01;
      end
    end
  end
endmodule : vmu_map_mem
`default_nettype wire

// [tb/virtual_memory_unit_bench.sv]
// Self-checking bench for the virtual memory unit
`timescale 1ns/1ps
`default_nettype none
`include "vmu_params.svh"
// ********
// Bench
// ********
module virtual_memory_unit_bench;
  localparam int IC = 8;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [6:0]  av_addr = 7'h00;
  logic        av_rd = 1'b0, av_wr = 1'b0, av_wait;
  logic [31:0] av_wd = 32'h0, av_rdata;
  logic        cm_req = 1'b0, cpu_req = 1'b0, pm_req = 1'b0;
  logic [31:0] cm_addr = 32'h0, cpu_addr = 32'h0, pm_addr = 32'h0;
  logic        cpu_rdy, pm_rdy, cmc_req, pmc_req, pmc_map, map_v, irq, lock;
  logic [31:0] cmc_addr, pmc_addr, map_d, entry = 32'h0;
  logic [3:0]  lag = 4'h0;
  logic [31:0] seed = 32'h0000a006;
  logic [31:0] cb, pb, vb, po, mb, rb, a, r;
  logic [33:0] evq[$];
  int          fail_count = 0, cmp_count = 0, n;

  always #2.5 clk_sys_i = ~clk_sys_i;

  virtual_memory_unit #(.INIT_CYCLES(IC)) virtual_memory_unit_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(av_addr),
    .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(av_rdata),
    .avs_waitrequest_o(av_wait), .cm_req_i(cm_req), .cm_addr_i(cm_addr),
    .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr), .cpu_ready_o(cpu_rdy),
    .pm_req_i(pm_req), .pm_addr_i(pm_addr), .pm_ready_o(pm_rdy),
    .cmc_req_o(cmc_req), .cmc_addr_o(cmc_addr), .pmc_req_o(pmc_req),
    .pmc_addr_o(pmc_addr), .pmc_map_o(pmc_map), .map_valid_i(map_v),
    .map_rdata_i(map_d), .irq_o(irq), .mem_lock_o(lock));

  vmu_map_mem vmu_map_mem_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .fetch_i(pmc_req & pmc_map),
    .entry_i(entry), .lag_i(lag), .valid_o(map_v), .rdata_o(map_d));

  // Every forward to either controller, in order: {control, map, addr}
  always @(posedge clk_sys_i) begin
    if (cmc_req === 1'b1) evq.push_back({2'b10, cmc_addr});
    if (pmc_req === 1'b1) evq.push_back({1'b0, pmc_map, pmc_addr});
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] vaddr(logic [31:0] off, e, int sh);
    return rb + off + ({16'h0, e[15:0]} << sh);
  endfunction : vaddr

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [6:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys_i);
    av_addr <= ad;
    av_wd <= d;
    av_rd <= !w;
    av_wr <= w;
    // Wait as long as the slave asks; only the watchdog ends a hang
    do begin
      @(posedge clk_sys_i);
    end while (av_wait !== 1'b0);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : bus

  task automatic wr(input logic [6:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask : wr

  task automatic rdchk(input logic [6:0] ad, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 32'h0, q);
    check({2'b00, q}, {2'b00, e});
  endtask : rdchk

  // Kind 0 control bus pulse, 1 processor, 2 packet bus held until ready
  task automatic send(input logic [1:0] k, input logic [31:0] ad);
    @(posedge clk_sys_i);
    cm_req <= (k == 2'd0);
    cpu_req <= (k == 2'd1);
    pm_req <= (k == 2'd2);
    cm_addr <= ad;
    cpu_addr <= ad;
    pm_addr <= ad;
    do begin
      @(posedge clk_sys_i);
    end while (k != 2'd0 && (k == 2'd1 ? cpu_rdy : pm_rdy) !== 1'b1);
    cm_req <= 1'b0;
    cpu_req <= 1'b0;
    pm_req <= 1'b0;
  endtask : send

  task automatic expect_q(input logic [33:0] e);
    int c;
    c = 0;
    while (evq.size() == 0 && c < 80) begin
      @(posedge clk_sys_i);
      c++;
    end
    if (evq.size() == 0) check(~e, e);
    else check(evq.pop_front(), e);
  endtask : expect_q

  task automatic virt(input logic [31:0] idx, off, input int sh,
                      input bit drop);
    logic [31:0] e;
    e = rnd();
    entry <= e;
    lag <= e[19:16];
    send(2'd2, vb + (idx << sh) + off);
    if (drop) begin
      repeat (12) @(posedge clk_sys_i);
      check({2'b00, 32'(evq.size())}, 34'h0);
    end else begin
      expect_q({2'b01, mb + po + (idx << 3)});
      expect_q({2'b00, vaddr(off, e, sh) + po});
      rdchk(`VMU_OFS_LAST_REAL, vaddr(off, e, sh));
    end
  endtask : virt

  // Whole run is under a thousand cycles; this bound of 50000 cycles is far beyond it
  initial begin
    #250000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rdchk(`VMU_OFS_MAX_BUF, 32'hffffffff);
    rdchk(`VMU_OFS_BUF_SIZE, 32'h0000000c);
    rdchk(`VMU_OFS_STATE, 32'h00000005);
    wr(7'h7c, 32'h5a5a5a5a);
    rdchk(7'h7c, 32'h0);
    cb = rnd();
    wr(`VMU_OFS_CM_BASE, cb);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? cb - 32'h1 : rnd();
      send(2'd0, a);
      expect_q({2'b10, a - cb});
    end
    pb = 32'h40000000;
    vb = 32'h80000000;
    po = rnd() & 32'h00fffff0;
    wr(`VMU_OFS_PM_BASE, pb);
    wr(`VMU_OFS_VBASE, vb);
    wr(`VMU_OFS_PM_OFS, po);
    send(2'd1, pb - 32'h1);
    expect_q({2'b10, pb - 32'h1 - cb});
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? pb : (i == 1) ? vb - 32'h1 : pb + (rnd() & 32'h3fffffff);
      send(i[0] ? 2'd2 : 2'd1, a);
      expect_q({2'b00, a - pb + po});
    end
    mb = rnd() & 32'h00ff0000;
    rb = rnd() & 32'h0ff00000;
    wr(`VMU_OFS_MAP_BASE, mb);
    wr(`VMU_OFS_REAL_BASE, rb);
    wr(`VMU_OFS_BUF_SIZE, 32'h8);
    wr(`VMU_OFS_TOTAL, 32'h1000);
    for (int i = 0; i < 6; i++) begin
      virt(i == 0 ? 32'hf : rnd() & 32'hf, rnd() & 32'hff, 8, 0);
    end
    rdchk(`VMU_OFS_STATUS, 32'h0);
    wr(`VMU_OFS_INT_EN, 32'h1);
    virt(32'h10, 32'h0, 8, 0);
    rdchk(`VMU_OFS_STATUS, 32'h1);
    check({33'h0, irq}, 34'h1);
    check({33'h0, lock}, 34'h0);
    wr(`VMU_OFS_LOCK_EN, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    check({33'h0, lock}, 34'h1);
    wr(`VMU_OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    check({33'h0, irq | lock}, 34'h0);
    wr(`VMU_OFS_CTRL, 32'h1);
    virt(32'h11, 32'h4, 8, 1);
    rdchk(`VMU_OFS_STATUS, 32'h1);
    wr(`VMU_OFS_STATUS, 32'h1);
    wr(`VMU_OFS_BUF_SIZE, 32'hd);
    wr(`VMU_OFS_TOTAL, 32'h8000);
    wr(`VMU_OFS_MAX_BUF, 32'hff8);
    wr(`VMU_OFS_CTRL, 32'h2);
    wr(`VMU_OFS_INT_EN, 32'h2);
    virt(32'h1, 32'hfff, 13, 0);
    rdchk(`VMU_OFS_STATUS, 32'h0);
    virt(32'h3, 32'h1000, 13, 1);
    rdchk(`VMU_OFS_STATUS, 32'h2);
    check({33'h0, irq}, 34'h1);
    wr(`VMU_OFS_STATUS, 32'h2);
    wr(`VMU_OFS_SEG_SIZE, rnd());
    @(posedge clk_sys_i);
    check({33'h0, pm_rdy}, 34'h0);
    rdchk(`VMU_OFS_STATE, 32'h6);
    n = 0;
    r = 32'h0;
    while (r !== 32'h5 && n < 20) begin
      bus(1'b0, `VMU_OFS_STATE, 32'h0, r);
      n++;
    end
    check({2'b00, r}, 34'h5);
    report_and_stop();
  end
endmodule : virtual_memory_unit_bench
`default_nettype wire
